/* src/iwu_consts.svh */
// constants of the interrupt and wake-up unit: offsets, widths, field positions, reset values
//
// What this block does
// - collect peripheral and pin requests and raise a request toward the cpu core
// - each maskable source has its own software enable before reaching the cpu
// - sixteen maskable lines, fixed priority, lowest line number presented first
// - pin-driven non-maskable request outranks every maskable one, no enable blocks it
// - wake channels not selected for mode exit merge into one combined request toward the arbiter
// - every wake channel has its own enable, independent of the other seven
// - every wake channel selects rising or falling edge by software
// - an enabled wake channel event can end halt, idle or power-save
// - wake channels not used for mode exit act as edge-triggered maskable interrupts
`ifndef IWU_CONSTS_SVH
`define IWU_CONSTS_SVH

`define IWU_AW          8
`define IWU_DW          32
`define IWU_NLINES      16
`define IWU_VW          4
`define IWU_NCHAN       8
`define IWU_NSTAT       3
`define IWU_SYNC        3
`define IWU_WAKE_LINE   4'h7

`define IWU_OFF_IRQ_ENA  8'h00
`define IWU_OFF_IRQ_RAW  8'h04
`define IWU_OFF_IRQ_VEC  8'h08
`define IWU_OFF_WK_ENA   8'h0C
`define IWU_OFF_WK_EDGE  8'h10
`define IWU_OFF_WK_PEND  8'h14
`define IWU_OFF_WK_EXIT  8'h18
`define IWU_OFF_STAT     8'h1C
`define IWU_OFF_MASK     8'h20

`define IWU_ST_NMI      0
`define IWU_ST_WEXIT    1
`define IWU_ST_INT      2

`define IWU_RST_LINES   16'h0000
`define IWU_RST_CHAN    8'h00
`define IWU_RST_STAT    3'h0
`define IWU_RST_DATA    32'h0000_0000

`endif

/* src/iwu_pkg.sv */
// types shared by the interrupt and wake-up unit
`include "iwu_consts.svh"
package iwu_pkg;
  typedef logic [`IWU_AW-1:0]     iwu_addr_t;
  typedef logic [`IWU_DW-1:0]     iwu_data_t;
  typedef logic [`IWU_NLINES-1:0] iwu_lines_t;
  typedef logic [`IWU_VW-1:0]     iwu_vec_t;
  typedef logic [`IWU_NCHAN-1:0]  iwu_chan_t;
  typedef logic [`IWU_NSTAT-1:0]  iwu_stat_t;
endpackage : iwu_pkg

/* src/iwu_edge_wake_block.sv */
// eight-channel edge-triggered wake block with pending latches
`timescale 1ns/1ps
`include "iwu_consts.svh"
module iwu_edge_wake_block
  import iwu_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      sys_rst,
  input  wire iwu_chan_t wake_pin,
  input  wire iwu_chan_t chan_ena,
  input  wire iwu_chan_t edge_fall,
  input  wire iwu_chan_t exit_sel,
  input  wire iwu_chan_t clr,
  output iwu_chan_t      pend,
  output iwu_chan_t      lvl,
  output logic           wake_irq,
  output logic           wake_exit
);
  for (genvar g = 0; g < `IWU_NCHAN; g++) begin : g_ch
    logic [`IWU_SYNC-1:0] sync_ff, nxt_sync;
    logic                 lvl_ff, nxt_lvl;
    logic                 pend_ff, nxt_pend;
    logic                 hit;
    always_comb begin
      nxt_sync = {sync_ff[`IWU_SYNC-2:0], wake_pin[g]};
      nxt_lvl  = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : lvl_ff;
      hit      = (nxt_lvl != lvl_ff) && (nxt_lvl == ~edge_fall[g]);
      nxt_pend = (pend_ff & ~clr[g]) | (hit & chan_ena[g]);
    end
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        sync_ff <= 3'h0;
        lvl_ff  <= 1'b0;
        pend_ff <= 1'b0;
      end else begin
        sync_ff <= nxt_sync;
        lvl_ff  <= nxt_lvl;
        pend_ff <= nxt_pend;
      end
    end
    assign pend[g] = pend_ff;
    assign lvl[g]  = lvl_ff;
  end

  assign wake_irq  = |(pend & chan_ena & ~exit_sel);
  assign wake_exit = |(pend & chan_ena & exit_sel);

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_dis_no_latch;
    ((pend & ~$past(pend) & ~$past(chan_ena)) == 8'h00);
  endproperty
  a_dis_no_latch: assert property (p_dis_no_latch) else $error("disabled wake channel latched");

  property p_edge_dir;
    ((pend & ~$past(pend) & ~(($past(lvl) ^ lvl) & (lvl ^ $past(edge_fall)))) == 8'h00);
  endproperty
  a_edge_dir: assert property (p_edge_dir) else $error("wake pending set on wrong edge");
endmodule : iwu_edge_wake_block

/* src/iwu_irq_arbiter.sv */
// fixed-priority arbiter for the sixteen maskable lines
`timescale 1ns/1ps
`include "iwu_consts.svh"
module iwu_irq_arbiter
  import iwu_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire iwu_lines_t req,
  input  wire iwu_lines_t ena,
  input  wire logic       nmi_busy,
  output logic            int_req,
  output iwu_vec_t        int_vec
);
  iwu_lines_t live;
  logic       req_ff, nxt_req;
  iwu_vec_t   vec_ff, nxt_vec;

  always_comb begin
    live    = req & ena;
    nxt_vec = 4'h0;
    for (int i = `IWU_NLINES - 1; i >= 0; i--) begin
      if (live[i]) begin
        nxt_vec = iwu_vec_t'(i);
      end
    end
    nxt_req = (live != 16'h0000) && !nmi_busy;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req_ff <= 1'b0;
      vec_ff <= 4'h0;
    end else begin
      req_ff <= nxt_req;
      vec_ff <= nxt_vec;
    end
  end

  assign int_req = req_ff;
  assign int_vec = vec_ff;

  property p_arb_nmi;
    @(posedge clk) disable iff (sys_rst) nmi_busy |=> !int_req;
  endproperty
  a_arb_nmi: assert property (p_arb_nmi) else $error("maskable request beside nmi");
endmodule : iwu_irq_arbiter

/* src/iwu_top.sv */
// top of the interrupt and wake-up unit: register port, nmi input, status and glue
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "iwu_consts.svh"
module iwu_top
  import iwu_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire iwu_addr_t  reg_addr,
  input  wire iwu_data_t  reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output iwu_data_t       reg_rdata,
  input  wire iwu_lines_t periph_req,
  input  wire logic       nmi_pin,
  input  wire iwu_chan_t  wake_pin,
  output logic            cpu_int_req,
  output iwu_vec_t        cpu_int_vec,
  output logic            cpu_nmi_req,
  input  wire logic       cpu_nmi_ack,
  output logic            wake_exit,
  output logic            irq
);
  // software registers
  iwu_lines_t           irq_ena_ff;
  iwu_lines_t           nxt_irq_ena;
  iwu_chan_t            wk_ena_ff;
  iwu_chan_t            nxt_wk_ena;
  iwu_chan_t            wk_edge_ff;
  iwu_chan_t            nxt_wk_edge;
  iwu_chan_t            wk_exit_ff;
  iwu_chan_t            nxt_wk_exit;
  iwu_stat_t            mask_ff;
  iwu_stat_t            nxt_mask;
  iwu_stat_t            st_ff;
  iwu_stat_t            nxt_st;
  iwu_stat_t            st_clr;
  iwu_stat_t            st_set;
  iwu_data_t            rdata_ff;
  iwu_data_t            nxt_rdata;
  iwu_chan_t            wk_clr;

  // nmi input path
  logic [`IWU_SYNC-1:0] nmi_sync_ff;
  logic [`IWU_SYNC-1:0] nxt_nmi_sync;
  logic                 nmi_lvl_ff;
  logic                 nxt_nmi_lvl;
  logic                 nmi_pend_ff;
  logic                 nxt_nmi_pend;
  logic                 nmi_rise;

  // event edge memory for status
  logic                 wexit_d_ff;
  logic                 nxt_wexit_d;
  logic                 int_d_ff;
  logic                 nxt_int_d;

  // wake block and request lines
  iwu_chan_t            wk_pend;
  iwu_chan_t            wk_lvl;
  logic                 wk_irq;
  logic                 wk_exit_lvl;
  iwu_lines_t           lines;
  iwu_lines_t           live_req;

  // request lines toward the arbiter
  always_comb begin
    lines                 = periph_req;
    lines[`IWU_WAKE_LINE] = wk_irq;
  end

  assign live_req = lines & irq_ena_ff;

  // register writes
  always_comb begin
    nxt_irq_ena = irq_ena_ff;
    nxt_wk_ena  = wk_ena_ff;
    nxt_wk_edge = wk_edge_ff;
    nxt_wk_exit = wk_exit_ff;
    nxt_mask    = mask_ff;
    wk_clr      = 8'h00;
    st_clr      = 3'h0;
    if (reg_wr) begin
      case (reg_addr)
        `IWU_OFF_IRQ_ENA: begin
          nxt_irq_ena = reg_wdata[`IWU_NLINES-1:0];
        end
        `IWU_OFF_WK_ENA: begin
          nxt_wk_ena = reg_wdata[`IWU_NCHAN-1:0];
        end
        `IWU_OFF_WK_EDGE: begin
          nxt_wk_edge = reg_wdata[`IWU_NCHAN-1:0];
        end
        `IWU_OFF_WK_PEND: begin
          wk_clr = reg_wdata[`IWU_NCHAN-1:0];
        end
        `IWU_OFF_WK_EXIT: begin
          nxt_wk_exit = reg_wdata[`IWU_NCHAN-1:0];
        end
        `IWU_OFF_STAT: begin
          st_clr = reg_wdata[`IWU_NSTAT-1:0];
        end
        `IWU_OFF_MASK: begin
          nxt_mask = reg_wdata[`IWU_NSTAT-1:0];
        end
        default: begin
          wk_clr = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_ena_ff <= `IWU_RST_LINES;
      wk_ena_ff  <= `IWU_RST_CHAN;
      wk_edge_ff <= `IWU_RST_CHAN;
      wk_exit_ff <= `IWU_RST_CHAN;
      mask_ff    <= `IWU_RST_STAT;
    end else begin
      irq_ena_ff <= nxt_irq_ena;
      wk_ena_ff  <= nxt_wk_ena;
      wk_edge_ff <= nxt_wk_edge;
      wk_exit_ff <= nxt_wk_exit;
      mask_ff    <= nxt_mask;
    end
  end

  // register reads, data in the cycle after the strobe only
  always_comb begin
    nxt_rdata = `IWU_RST_DATA;
    if (reg_rd) begin
      case (reg_addr)
        `IWU_OFF_IRQ_ENA: nxt_rdata[`IWU_NLINES-1:0] = irq_ena_ff;
        `IWU_OFF_IRQ_RAW: nxt_rdata[`IWU_NLINES-1:0] = lines;
        `IWU_OFF_IRQ_VEC: nxt_rdata[5:0] = {cpu_nmi_req, cpu_int_req, cpu_int_vec};
        `IWU_OFF_WK_ENA:  nxt_rdata[`IWU_NCHAN-1:0] = wk_ena_ff;
        `IWU_OFF_WK_EDGE: nxt_rdata[`IWU_NCHAN-1:0] = wk_edge_ff;
        `IWU_OFF_WK_PEND: nxt_rdata[`IWU_NCHAN-1:0] = wk_pend;
        `IWU_OFF_WK_EXIT: nxt_rdata[`IWU_NCHAN-1:0] = wk_exit_ff;
        `IWU_OFF_STAT:    nxt_rdata[`IWU_NSTAT-1:0] = st_ff;
        `IWU_OFF_MASK:    nxt_rdata[`IWU_NSTAT-1:0] = mask_ff;
        default:          nxt_rdata = `IWU_RST_DATA;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_ff <= `IWU_RST_DATA;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // nmi pin: three-stage sync, level filter, latched until cpu acknowledge
  always_comb begin
    nxt_nmi_sync = {nmi_sync_ff[`IWU_SYNC-2:0], nmi_pin};
    nxt_nmi_lvl  = (nmi_sync_ff[1] == nmi_sync_ff[2]) ? nmi_sync_ff[2] : nmi_lvl_ff;
    nmi_rise     = nxt_nmi_lvl & ~nmi_lvl_ff;
    nxt_nmi_pend = (nmi_pend_ff & ~cpu_nmi_ack) | nmi_rise;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      nmi_sync_ff <= 3'h0;
      nmi_lvl_ff  <= 1'b0;
      nmi_pend_ff <= 1'b0;
    end else begin
      nmi_sync_ff <= nxt_nmi_sync;
      nmi_lvl_ff  <= nxt_nmi_lvl;
      nmi_pend_ff <= nxt_nmi_pend;
    end
  end

  assign cpu_nmi_req = nmi_pend_ff;

  // sticky status, set wins over write-one-to-clear
  always_comb begin
    nxt_wexit_d            = wk_exit_lvl;
    nxt_int_d              = cpu_int_req;
    st_set                 = 3'h0;
    st_set[`IWU_ST_NMI]    = nmi_rise;
    st_set[`IWU_ST_WEXIT]  = wk_exit_lvl & ~wexit_d_ff;
    st_set[`IWU_ST_INT]    = cpu_int_req & ~int_d_ff;
    nxt_st                 = (st_ff & ~st_clr) | st_set;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff      <= `IWU_RST_STAT;
      wexit_d_ff <= 1'b0;
      int_d_ff   <= 1'b0;
    end else begin
      st_ff      <= nxt_st;
      wexit_d_ff <= nxt_wexit_d;
      int_d_ff   <= nxt_int_d;
    end
  end

  assign irq       = |(st_ff & mask_ff);
  assign wake_exit = wk_exit_lvl;

  iwu_edge_wake_block u_wake (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .wake_pin  (wake_pin),
    .chan_ena  (wk_ena_ff),
    .edge_fall (wk_edge_ff),
    .exit_sel  (wk_exit_ff),
    .clr       (wk_clr),
    .pend      (wk_pend),
    .lvl       (wk_lvl),
    .wake_irq  (wk_irq),
    .wake_exit (wk_exit_lvl)
  );

  iwu_irq_arbiter u_arb (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .req      (lines),
    .ena      (irq_ena_ff),
    .nmi_busy (nmi_pend_ff),
    .int_req  (cpu_int_req),
    .int_vec  (cpu_int_vec)
  );

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_ena_write;
    (reg_wr && reg_addr == `IWU_OFF_IRQ_ENA) |=> (irq_ena_ff == $past(reg_wdata[`IWU_NLINES-1:0]));
  endproperty
  a_ena_write: assert property (p_ena_write) else $error("enable write not taken");

  property p_vec_highest;
    cpu_int_req |-> ((($past(live_req) >> cpu_int_vec) & 16'h0001) == 16'h0001)
                    && (($past(live_req) & ~(16'hFFFF << cpu_int_vec)) == 16'h0000);
  endproperty
  a_vec_highest: assert property (p_vec_highest) else $error("vector not highest pending");

  property p_nmi_first;
    cpu_nmi_req |=> !cpu_int_req;
  endproperty
  a_nmi_first: assert property (p_nmi_first) else $error("maskable request beside nmi");

  property p_nmi_take;
    (nmi_sync_ff[2] && nmi_sync_ff[1] && !nmi_lvl_ff) |=> cpu_nmi_req ##1 (cpu_nmi_req || $past(cpu_nmi_ack));
  endproperty
  a_nmi_take: assert property (p_nmi_take) else $error("nmi edge not latched");

  property p_deliver;
    (live_req != 16'h0000 && !cpu_nmi_req) |=> cpu_int_req;
  endproperty
  a_deliver: assert property (p_deliver) else $error("enabled request not delivered");

  property p_late_enable;
    (lines[0] && !irq_ena_ff[0] && !cpu_nmi_req) ##1 (irq_ena_ff[0] && lines[0] && !cpu_nmi_req)
      |=> (cpu_int_req && cpu_int_vec == 4'h0);
  endproperty
  a_late_enable: assert property (p_late_enable) else $error("held request lost");

  property p_wake_merge;
    (wk_irq && irq_ena_ff[`IWU_WAKE_LINE] && !cpu_nmi_req) |=> cpu_int_req;
  endproperty
  a_wake_merge: assert property (p_wake_merge) else $error("wake request not merged");

  property p_wake_hold;
    (|($past(wk_pend) & ~wk_pend)) |-> $past(reg_wr && reg_addr == `IWU_OFF_WK_PEND);
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("wake pending dropped");

  property p_exit_stat;
    $rose(wake_exit) |=> st_ff[`IWU_ST_WEXIT];
  endproperty
  a_exit_stat: assert property (p_exit_stat) else $error("exit event not recorded");

  property p_rd_data;
    (reg_rd && reg_addr == `IWU_OFF_WK_ENA) |=> (reg_rdata == {24'h00_0000, $past(wk_ena_ff)});
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data wrong");

  property p_irq_out;
    $rose(st_ff[`IWU_ST_NMI]) && mask_ff[`IWU_ST_NMI] |-> irq;
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("interrupt output missing");

  c_nmi:    cover property (cpu_nmi_req ##1 cpu_nmi_ack);
  c_exit:   cover property ($rose(wake_exit));
  c_vec:    cover property (cpu_int_req && cpu_int_vec == `IWU_WAKE_LINE);
  c_wk_clr: cover property ((reg_wr && reg_addr == `IWU_OFF_WK_PEND) ##1 (wk_pend == 8'h00));
endmodule : iwu_top

/* tb/iwu_cpu_model.sv */
// behavioural cpu core that takes nmi requests and acknowledges them after a set delay
`timescale 1ns/1ps
module iwu_cpu_model
  import iwu_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       cpu_int_req,
  input  wire iwu_vec_t   cpu_int_vec,
  input  wire logic       cpu_nmi_req,
  input  wire logic [3:0] ack_delay,
  output logic            cpu_nmi_ack
);
  logic [3:0] cnt_ff;

  // the handler runs for ack_delay + 1 cycles, then the core acks and resumes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_ff      <= 4'h0;
      cpu_nmi_ack <= 1'b0;
    end else begin
      cpu_nmi_ack <= 1'b0;
      if (cpu_nmi_req && !cpu_nmi_ack) begin
        if (cnt_ff == ack_delay) begin
          cpu_nmi_ack <= 1'b1;
          cnt_ff      <= 4'h0;
        end else begin
          cnt_ff <= cnt_ff + 4'h1;
        end
      end else begin
        cnt_ff <= 4'h0;
      end
    end
  end
endmodule : iwu_cpu_model

/* tb/tb.sv */
// self-checking testbench of the interrupt and wake-up unit
`timescale 1ns/1ps
`include "iwu_consts.svh"
module tb
  import iwu_pkg::*;
;
  logic       clk;
  logic       sys_rst;
  iwu_addr_t  reg_addr;
  iwu_data_t  reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  iwu_data_t  reg_rdata;
  iwu_lines_t periph_req;
  logic       nmi_pin;
  iwu_chan_t  wake_pin;
  logic       cpu_int_req;
  iwu_vec_t   cpu_int_vec;
  logic       cpu_nmi_req;
  logic       cpu_nmi_ack;
  logic       wake_exit;
  logic       irq;
  logic [3:0] ack_delay;
  int         err_count;
  int         comparisons;
  int         cycles;

  iwu_top iwu_top_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .periph_req(periph_req),
    .nmi_pin(nmi_pin), .wake_pin(wake_pin), .cpu_int_req(cpu_int_req), .cpu_int_vec(cpu_int_vec),
    .cpu_nmi_req(cpu_nmi_req), .cpu_nmi_ack(cpu_nmi_ack), .wake_exit(wake_exit), .irq(irq));

  iwu_cpu_model iwu_cpu_model_i (.clk(clk), .sys_rst(sys_rst), .cpu_int_req(cpu_int_req),
    .cpu_int_vec(cpu_int_vec), .cpu_nmi_req(cpu_nmi_req), .ack_delay(ack_delay),
    .cpu_nmi_ack(cpu_nmi_ack));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count = err_count + 1;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input iwu_addr_t a, input iwu_data_t d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input iwu_addr_t a, input iwu_data_t exp, input string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, exp, reg_rdata);
  endtask : rd

  task automatic cpu(input logic req, input iwu_vec_t vec);
    repeat (3) @(posedge clk);
    #1;
    chk("cpu_int_req", {31'h0, req}, {31'h0, cpu_int_req});
    chk("cpu_int_vec", {28'h0, vec}, {28'h0, cpu_int_vec});
  endtask : cpu

  task automatic t_reset();
    rd(`IWU_OFF_IRQ_ENA, 32'h0000_0000, "irq_ena");
    rd(`IWU_OFF_WK_ENA, 32'h0000_0000, "wk_ena");
    rd(`IWU_OFF_STAT, 32'h0000_0000, "stat");
    wr(`IWU_OFF_IRQ_ENA, 32'hFFFF_FFFF);
    rd(`IWU_OFF_IRQ_ENA, 32'h0000_FFFF, "irq_ena");
    wr(8'hFC, 32'hFFFF_FFFF);
    rd(8'hFC, 32'h0000_0000, "unmapped");
    $display("test reset done");
  endtask : t_reset

  task automatic t_prio();
    for (int i = 0; i < 16; i++) begin
      if (i != 7) begin
        @(posedge clk);
        periph_req <= (16'hFFFF << i) & 16'hFF7F;
        cpu(1'b1, iwu_vec_t'(i));
      end
    end
    @(posedge clk);
    periph_req <= 16'h0208;
    cpu(1'b1, 4'h3);
    @(posedge clk);
    periph_req <= 16'h0200;
    cpu(1'b1, 4'h9);
    wr(`IWU_OFF_IRQ_ENA, 32'h0000_0000);
    cpu(1'b0, 4'h0);
    rd(`IWU_OFF_IRQ_RAW, 32'h0000_0200, "irq_raw");
    wr(`IWU_OFF_IRQ_ENA, 32'h0000_0200);
    cpu(1'b1, 4'h9);
    rd(`IWU_OFF_IRQ_VEC, 32'h0000_0019, "irq_vec");
    @(posedge clk);
    periph_req <= 16'h0000;
    $display("test priority done");
  endtask : t_prio

  task automatic t_nmi(input logic [3:0] dly);
    @(posedge clk);
    ack_delay  <= dly;
    periph_req <= 16'h0001;
    wr(`IWU_OFF_IRQ_ENA, 32'h0000_0001);
    wr(`IWU_OFF_MASK, 32'h0000_0001);
    wr(`IWU_OFF_STAT, 32'h0000_0007);
    cpu(1'b1, 4'h0);
    @(posedge clk);
    nmi_pin <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    if (dly > 4'h3) begin
      chk("cpu_nmi_req", 32'h1, {31'h0, cpu_nmi_req});
      chk("cpu_int_req", 32'h0, {31'h0, cpu_int_req});
      chk("irq", 32'h1, {31'h0, irq});
    end
    for (int n = 0; n < 20 && cpu_nmi_req !== 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
    chk("cpu_nmi_req", 32'h0, {31'h0, cpu_nmi_req});
    cpu(1'b1, 4'h0);
    rd(`IWU_OFF_STAT, 32'h0000_0005, "stat");
    wr(`IWU_OFF_STAT, 32'h0000_0007);
    rd(`IWU_OFF_STAT, 32'h0000_0000, "stat");
    chk("irq", 32'h0, {31'h0, irq});
    @(posedge clk);
    nmi_pin    <= 1'b0;
    periph_req <= 16'h0000;
    $display("test nmi done");
  endtask : t_nmi

  task automatic t_wake();
    wr(`IWU_OFF_IRQ_ENA, 32'h0000_0080);
    wr(`IWU_OFF_WK_EDGE, 32'h0000_0020);
    wr(`IWU_OFF_WK_ENA, 32'h0000_0024);
    rd(`IWU_OFF_WK_EDGE, 32'h0000_0020, "wk_edge");
    @(posedge clk);
    wake_pin <= 8'h22;
    repeat (2) @(posedge clk);
    cpu(1'b0, 4'h0);
    rd(`IWU_OFF_WK_PEND, 32'h0000_0000, "wk_pend");
    @(posedge clk);
    wake_pin <= 8'h26;
    repeat (2) @(posedge clk);
    cpu(1'b1, 4'h7);
    rd(`IWU_OFF_WK_PEND, 32'h0000_0004, "wk_pend");
    @(posedge clk);
    wake_pin <= 8'h22;
    repeat (2) @(posedge clk);
    cpu(1'b1, 4'h7);
    wr(`IWU_OFF_WK_PEND, 32'h0000_0004);
    cpu(1'b0, 4'h0);
    rd(`IWU_OFF_WK_PEND, 32'h0000_0000, "wk_pend");
    @(posedge clk);
    wake_pin <= 8'h02;
    repeat (2) @(posedge clk);
    cpu(1'b1, 4'h7);
    wr(`IWU_OFF_WK_EXIT, 32'h0000_0020);
    cpu(1'b0, 4'h0);
    chk("wake_exit", 32'h1, {31'h0, wake_exit});
    rd(`IWU_OFF_WK_EXIT, 32'h0000_0020, "wk_exit");
    rd(`IWU_OFF_STAT, 32'h0000_0006, "stat");
    wr(`IWU_OFF_WK_PEND, 32'h0000_0020);
    cpu(1'b0, 4'h0);
    chk("wake_exit", 32'h0, {31'h0, wake_exit});
    $display("test wake done");
  endtask : t_wake

  initial begin
    sys_rst     = 1'b1;
    reg_addr    = 8'h00;
    reg_wdata   = 32'h0000_0000;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    periph_req  = 16'h0000;
    nmi_pin     = 1'b0;
    wake_pin    = 8'h20;
    ack_delay   = 4'h6;
    err_count   = 0;
    comparisons = 0;
    cycles      = 0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_prio();
    t_nmi(4'h6);
    t_nmi(4'h1);
    t_wake();
    report_and_stop();
  end
endmodule : tb
